/* File: logic/ccd_vertical_field_sequencer.sv */
// Field-level vertical sequencer with AXI4-Lite register access
// Behaviour
// - insert enable replaces one group A repetition by the group B, C or D pattern
// - group B repeat count names the repetition that gets the inserted pattern
// - insert enable bit 0 (group B) wins over bits 1 and 2
// - advance flag of the active sequence adds one to the sequence at line end
// - return flag reloads the region's own sequence choice at line end
// - looping continues each line until the next region boundary takes over
// - sequence stepping happens only at line ends, never within a line
// - a field holds up to nine regions with independent sequences
// - each region after the first starts at a 13-bit line number; region 0 always starts at line 0
// - each region holds a 5-bit sequence choice, 0 to 31
// - region mode: 0 none, 1 sweep, 2 multiplier, 3 both
// - a 13-bit line total sets the field length
// - ordinary lines use the line pixel total, the final line its own count
// - per-output pair choice: 0 uses toggles one and two, 1 three and four
// - per-output mask bit high suppresses that sensor gate pulse
// - separate second-line masking only when gate lines run different sequences
// - first gate line selects where sensor gate pulses appear
// - second gate line repeats the pulses; unused means equal to first or 8191
// - sweep regions let pulse trains run across line boundaries
// - multiplier regions place each toggle at toggle value times pattern length
//
// The placing of the registers and the AXI4-Lite interface to the registers were chosen for this implementation.
`include "ccd_vfs_map.svh"
module ccd_vertical_field_sequencer (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // AXI4-Lite write channels
  input wire logic [11:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // AXI4-Lite read channels
  input wire logic [11:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // Sensor clock lines
  output logic [23:0] vertical_out,
  output logic [23:0] sensor_gate_pulse_out,
  output logic line_sync_out
);

  typedef struct packed {
    logic run;
    logic [3:0] region_count;
    logic [12:0] field_line_total;
    logic [12:0] line_pixel_total;
    logic [12:0] final_line_pixels;
    logic [23:0] gate_toggle_pair_choice;
    logic [23:0] gate_output_mask;
    logic [23:0] gate_second_mask;
    logic [12:0] gate_first_line;
    logic [12:0] gate_second_line;
    logic [2:0] insert_pattern_enable;
    logic [12:0] group_a_repeat_count;
    logic [12:0] group_b_repeat_count;
    ccd_vfs_pkg::region_t [8:0] region;
    logic [31:0][1:0] seq_flag;
    logic [3:0][12:0] pattern_length;
    logic [3:0][3:0][12:0] toggle_pos;
    logic [12:0] pix;
    logic [12:0] line;
    logic [3:0] reg_idx;
    logic [4:0] seq;
    logic [12:0] rep;
    logic [25:0] ph;
    logic [4:0] first_gate_seq;
    logic [23:0] vout;
    logic [23:0] gout;
    logic lsync;
    logic aw_have;
    logic [11:0] awaddr;
    logic w_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_t;

  state_t s_q;
  state_t s_d;

  // Toggle place in pixels; multiplier stretches it by the pattern length
  function automatic logic [25:0] pos_f(input logic [12:0] tog, input logic [12:0] len, input logic mult);
    pos_f = mult ? 26'(tog) * 26'(len) : 26'(tog);
  endfunction : pos_f

  // Any count of zero acts as one, so counters never run away
  function automatic logic [12:0] last_f(input logic [12:0] n);
    last_f = (n == 13'h0000) ? 13'h0000 : n - 13'h0001;
  endfunction : last_f

  // Line position decode, shared by the sequencer and the checks
  logic on_last_line;
  logic line_end;
  logic boundary;
  logic [3:0] next_idx;
  logic sweep_on;
  logic mult_on;
  logic [1:0] grp;
  logic [25:0] rep_len;
  logic [12:0] rep_total;
  logic pat_active;
  logic on_gate1;
  logic on_gate2;

  assign on_last_line = s_q.line == last_f(s_q.field_line_total);
  assign line_end = s_q.run && (s_q.pix == last_f(on_last_line ? s_q.final_line_pixels : s_q.line_pixel_total));
  assign next_idx = s_q.reg_idx + 4'h1;
  // Next region takes over when the following line reaches its start
  assign boundary = (next_idx < s_q.region_count) && (next_idx < 4'(`VFS_REGIONS)) &&
                    (s_q.line + 13'h0001 == s_q.region[next_idx].start_line);
  assign sweep_on = s_q.region[s_q.reg_idx].wide_pulse_mode[0];
  assign mult_on = s_q.region[s_q.reg_idx].wide_pulse_mode[1];

  // Group of the current repetition; B beats C beats D
  always_comb begin
    grp = ccd_vfs_pkg::GRP_A;
    if (s_q.rep == s_q.group_b_repeat_count) begin
      if (s_q.insert_pattern_enable[0]) begin
        grp = ccd_vfs_pkg::GRP_B;
      end else if (s_q.insert_pattern_enable[1]) begin
        grp = ccd_vfs_pkg::GRP_C;
      end else if (s_q.insert_pattern_enable[2]) begin
        grp = ccd_vfs_pkg::GRP_D;
      end
    end
  end

  // Multiplier runs one long repetition of length times the repeat count
  assign rep_total = mult_on ? 13'h0001 : s_q.group_a_repeat_count;
  assign rep_len = mult_on ? 26'(s_q.pattern_length[grp]) * 26'(s_q.group_a_repeat_count)
                           : 26'(s_q.pattern_length[grp]);
  assign pat_active = s_q.run && (s_q.rep < rep_total);
  assign on_gate1 = s_q.line == s_q.gate_first_line;
  assign on_gate2 = (s_q.line == s_q.gate_second_line) && !on_gate1;

  // Next state: counters, sequence stepping, pattern engine, register bus
  always_comb begin
    logic [25:0] ta;
    logic [25:0] tb;
    logic lvl;
    logic [23:0] mask;
    logic [11:0] ra;
    logic [3:0] idx;
    logic restart;
    ta = 26'h0000000;
    tb = 26'h0000000;
    lvl = 1'b0;
    mask = 24'h000000;
    ra = 12'h000;
    idx = 4'h0;
    restart = 1'b0;
    s_d = s_q;

    // Pixel and line counters; the field wraps to line zero and region zero
    s_d.lsync = line_end;
    if (s_q.run) begin
      s_d.pix = line_end ? 13'h0000 : s_q.pix + 13'h0001;
    end
    if (line_end) begin
      if (on_last_line) begin
        s_d.line = 13'h0000;
        s_d.reg_idx = 4'h0;
        s_d.seq = s_q.region[0].pattern_choice;
        restart = 1'b1;
      end else begin
        s_d.line = s_q.line + 13'h0001;
        if (boundary) begin
          s_d.reg_idx = next_idx;
          s_d.seq = s_q.region[next_idx].pattern_choice;
          restart = 1'b1;
        end else if (s_q.seq_flag[s_q.seq][0]) begin
          s_d.seq = s_q.seq + 5'h01;
        end else if (s_q.seq_flag[s_q.seq][1]) begin
          s_d.seq = s_q.region[s_q.reg_idx].pattern_choice;
        end
      end
      // Outside sweep the pulse train is cut at each line end
      if (!sweep_on) begin
        restart = 1'b1;
      end
    end

    // Repetition engine
    if (restart || !s_q.run) begin
      s_d.rep = 13'h0000;
      s_d.ph = 26'h0000000;
    end else if (pat_active) begin
      if (s_q.ph >= rep_len - 26'h0000001 || rep_len == 26'h0000000) begin
        s_d.ph = 26'h0000000;
        s_d.rep = s_q.rep + 13'h0001;
      end else begin
        s_d.ph = s_q.ph + 26'h0000001;
      end
    end

    // Per-output level from the selected toggle pair
    if (on_gate1) begin
      s_d.first_gate_seq = s_q.seq;
    end
    // Second line keeps its own mask only when it runs another sequence
    mask = (on_gate2 && s_q.seq != s_q.first_gate_seq) ? s_q.gate_second_mask : s_q.gate_output_mask;
    for (int k = 0; k < `VFS_OUTS; k++) begin
      if (s_q.gate_toggle_pair_choice[k]) begin
        ta = pos_f(s_q.toggle_pos[grp][2], s_q.pattern_length[grp], mult_on);
        tb = pos_f(s_q.toggle_pos[grp][3], s_q.pattern_length[grp], mult_on);
      end else begin
        ta = pos_f(s_q.toggle_pos[grp][0], s_q.pattern_length[grp], mult_on);
        tb = pos_f(s_q.toggle_pos[grp][1], s_q.pattern_length[grp], mult_on);
      end
      lvl = pat_active && (s_q.ph >= ta) && (s_q.ph < tb);
      s_d.vout[k] = lvl && !(on_gate1 || on_gate2);
      s_d.gout[k] = lvl && (on_gate1 || on_gate2) && !mask[k];
    end

    // Write side: address and data may arrive in either order
    if (s_q.bvalid && s_axi_bready_in) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.awready && s_axi_awvalid_in) begin
      s_d.aw_have = 1'b1;
      s_d.awaddr = s_axi_awaddr_in;
    end
    if (s_q.wready && s_axi_wvalid_in) begin
      s_d.w_have = 1'b1;
      s_d.wdata = s_axi_wdata_in;
      s_d.wstrb = s_axi_wstrb_in;
    end
    if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
      s_d.aw_have = 1'b0;
      s_d.w_have = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = 2'h0;
      ra = {s_q.awaddr[11:2], 2'h0};
      // Byte strobes are honoured only as a whole word; partial writes are ignored
      if (s_q.wstrb != 4'hF) begin
        s_d.bresp = 2'h0;
      end else if (ra == `VFS_CTRL_OFS) begin
        s_d.run = s_q.wdata[`VFS_CTRL_RUN_BIT];
        s_d.region_count = s_q.wdata[`VFS_CTRL_CNT_LSB +: 4];
        s_d.pix = 13'h0000;
        s_d.line = 13'h0000;
        s_d.reg_idx = 4'h0;
        s_d.seq = s_q.region[0].pattern_choice;
        s_d.rep = 13'h0000;
        s_d.ph = 26'h0000000;
      end else if (ra == `VFS_LINE_TOTAL_OFS) begin
        s_d.field_line_total = s_q.wdata[12:0];
      end else if (ra == `VFS_PIX_TOTAL_OFS) begin
        s_d.line_pixel_total = s_q.wdata[12:0];
      end else if (ra == `VFS_LAST_PIX_OFS) begin
        s_d.final_line_pixels = s_q.wdata[12:0];
      end else if (ra == `VFS_PAIR_SEL_OFS) begin
        s_d.gate_toggle_pair_choice = s_q.wdata[23:0];
      end else if (ra == `VFS_MASK1_OFS) begin
        s_d.gate_output_mask = s_q.wdata[23:0];
      end else if (ra == `VFS_MASK2_OFS) begin
        s_d.gate_second_mask = s_q.wdata[23:0];
      end else if (ra == `VFS_SG_LINE1_OFS) begin
        s_d.gate_first_line = s_q.wdata[12:0];
      end else if (ra == `VFS_SG_LINE2_OFS) begin
        s_d.gate_second_line = s_q.wdata[12:0];
      end else if (ra == `VFS_INSERT_OFS) begin
        s_d.insert_pattern_enable = s_q.wdata[2:0];
      end else if (ra == `VFS_REP_A_OFS) begin
        s_d.group_a_repeat_count = s_q.wdata[12:0];
      end else if (ra == `VFS_REP_B_OFS) begin
        s_d.group_b_repeat_count = s_q.wdata[12:0];
      end else if (ra >= `VFS_REGION_OFS && ra < `VFS_REGION_END) begin
        idx = 4'((ra - `VFS_REGION_OFS) >> 2);
        s_d.region[idx].start_line = s_q.wdata[12:0];
        s_d.region[idx].pattern_choice = s_q.wdata[`VFS_REG_CHOICE_LSB +: 5];
        s_d.region[idx].wide_pulse_mode = s_q.wdata[`VFS_REG_MODE_LSB +: 2];
      end else if (ra >= `VFS_PLEN_OFS && ra < `VFS_PLEN_END) begin
        s_d.pattern_length[ra[3:2]] = s_q.wdata[12:0];
      end else if (ra >= `VFS_TOG_OFS && ra < `VFS_TOG_END) begin
        idx = 4'((ra - `VFS_TOG_OFS) >> 2);
        s_d.toggle_pos[idx[3:2]][idx[1:0]] = s_q.wdata[12:0];
      end else if (ra >= `VFS_SEQ_OFS && ra < `VFS_SEQ_END) begin
        s_d.seq_flag[ra[6:2]] = {s_q.wdata[`VFS_SEQ_RET_BIT], s_q.wdata[`VFS_SEQ_ADV_BIT]};
      end else begin
        s_d.bresp = 2'h2;
      end
    end
    // Ready only while the holding slot is free and no response is pending
    s_d.awready = !s_d.aw_have && !s_d.bvalid && !(s_q.awready && s_axi_awvalid_in);
    s_d.wready = !s_d.w_have && !s_d.bvalid && !(s_q.wready && s_axi_wvalid_in);

    // Read side: one beat, answered the cycle after the address is taken
    if (s_q.rvalid && s_axi_rready_in) begin
      s_d.rvalid = 1'b0;
    end
    if (s_q.arready && s_axi_arvalid_in) begin
      ra = {s_axi_araddr_in[11:2], 2'h0};
      s_d.rvalid = 1'b1;
      s_d.rresp = 2'h0;
      s_d.rdata = 32'h00000000;
      if (ra == `VFS_CTRL_OFS) begin
        s_d.rdata[`VFS_CTRL_RUN_BIT] = s_q.run;
        s_d.rdata[`VFS_CTRL_CNT_LSB +: 4] = s_q.region_count;
      end else if (ra == `VFS_LINE_TOTAL_OFS) begin
        s_d.rdata[12:0] = s_q.field_line_total;
      end else if (ra == `VFS_PIX_TOTAL_OFS) begin
        s_d.rdata[12:0] = s_q.line_pixel_total;
      end else if (ra == `VFS_LAST_PIX_OFS) begin
        s_d.rdata[12:0] = s_q.final_line_pixels;
      end else if (ra == `VFS_PAIR_SEL_OFS) begin
        s_d.rdata[23:0] = s_q.gate_toggle_pair_choice;
      end else if (ra == `VFS_MASK1_OFS) begin
        s_d.rdata[23:0] = s_q.gate_output_mask;
      end else if (ra == `VFS_MASK2_OFS) begin
        s_d.rdata[23:0] = s_q.gate_second_mask;
      end else if (ra == `VFS_SG_LINE1_OFS) begin
        s_d.rdata[12:0] = s_q.gate_first_line;
      end else if (ra == `VFS_SG_LINE2_OFS) begin
        s_d.rdata[12:0] = s_q.gate_second_line;
      end else if (ra == `VFS_INSERT_OFS) begin
        s_d.rdata[2:0] = s_q.insert_pattern_enable;
      end else if (ra == `VFS_REP_A_OFS) begin
        s_d.rdata[12:0] = s_q.group_a_repeat_count;
      end else if (ra == `VFS_REP_B_OFS) begin
        s_d.rdata[12:0] = s_q.group_b_repeat_count;
      end else if (ra == `VFS_STATUS_OFS) begin
        s_d.rdata[12:0] = s_q.line;
        s_d.rdata[`VFS_ST_REGION_LSB +: 4] = s_q.reg_idx;
        s_d.rdata[`VFS_ST_SEQ_LSB +: 5] = s_q.seq;
      end else if (ra >= `VFS_REGION_OFS && ra < `VFS_REGION_END) begin
        idx = 4'((ra - `VFS_REGION_OFS) >> 2);
        s_d.rdata[12:0] = s_q.region[idx].start_line;
        s_d.rdata[`VFS_REG_CHOICE_LSB +: 5] = s_q.region[idx].pattern_choice;
        s_d.rdata[`VFS_REG_MODE_LSB +: 2] = s_q.region[idx].wide_pulse_mode;
      end else if (ra >= `VFS_PLEN_OFS && ra < `VFS_PLEN_END) begin
        s_d.rdata[12:0] = s_q.pattern_length[ra[3:2]];
      end else if (ra >= `VFS_TOG_OFS && ra < `VFS_TOG_END) begin
        idx = 4'((ra - `VFS_TOG_OFS) >> 2);
        s_d.rdata[12:0] = s_q.toggle_pos[idx[3:2]][idx[1:0]];
      end else if (ra >= `VFS_SEQ_OFS && ra < `VFS_SEQ_END) begin
        s_d.rdata[`VFS_SEQ_ADV_BIT] = s_q.seq_flag[ra[6:2]][0];
        s_d.rdata[`VFS_SEQ_RET_BIT] = s_q.seq_flag[ra[6:2]][1];
      end else begin
        s_d.rresp = 2'h2;
      end
    end
    s_d.arready = !s_d.rvalid;
  end

  // State register; all control state starts from constants
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_q <= '0;
      s_q.region_count <= `VFS_REGION_CNT_RST;
      s_q.field_line_total <= `VFS_LINE_TOTAL_RST;
      s_q.line_pixel_total <= `VFS_PIX_TOTAL_RST;
      s_q.final_line_pixels <= `VFS_LAST_PIX_RST;
      s_q.gate_first_line <= `VFS_SG_LINE_RST;
      s_q.gate_second_line <= `VFS_SG_LINE_RST;
      s_q.awready <= 1'b1;
      s_q.wready <= 1'b1;
      s_q.arready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register
  assign s_axi_awready_out = s_q.awready;
  assign s_axi_wready_out = s_q.wready;
  assign s_axi_bvalid_out = s_q.bvalid;
  assign s_axi_bresp_out = s_q.bresp;
  assign s_axi_arready_out = s_q.arready;
  assign s_axi_rvalid_out = s_q.rvalid;
  assign s_axi_rdata_out = s_q.rdata;
  assign s_axi_rresp_out = s_q.rresp;
  assign vertical_out = s_q.vout;
  assign sensor_gate_pulse_out = s_q.gout;
  assign line_sync_out = s_q.lsync;

  // Stepping and region checks
  sequence s_plain_line_end;
    line_end && !on_last_line && !boundary;
  endsequence

  property p_step_only_at_line_end;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (s_q.seq != $past(s_q.seq)) |-> ($past(line_end) || $past(s_q.aw_have && s_q.w_have));
  endproperty
  a_step_only_at_line_end: assert property (p_step_only_at_line_end) else $error("sequence moved mid-line");

  property p_advance;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (s_plain_line_end and s_q.seq_flag[s_q.seq][0] && !(s_q.aw_have && s_q.w_have))
      |=> s_q.seq == $past(s_q.seq) + 5'h01;
  endproperty
  a_advance: assert property (p_advance) else $error("advance flag did not step sequence");

  property p_return;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (s_plain_line_end and !s_q.seq_flag[s_q.seq][0] && s_q.seq_flag[s_q.seq][1] && !(s_q.aw_have && s_q.w_have))
      |=> s_q.seq == s_q.region[s_q.reg_idx].pattern_choice;
  endproperty
  a_return: assert property (p_return) else $error("return flag did not reload region sequence");

  property p_field_wrap;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (line_end && on_last_line) |=> (s_q.line == 13'h0000 && s_q.reg_idx == 4'h0);
  endproperty
  a_field_wrap: assert property (p_field_wrap) else $error("field did not restart");

  property p_region_limit;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    s_q.reg_idx < 4'h9;
  endproperty
  a_region_limit: assert property (p_region_limit) else $error("region index past nine");

  property p_insert_priority;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (s_q.insert_pattern_enable[0] && s_q.rep == s_q.group_b_repeat_count) |-> grp == ccd_vfs_pkg::GRP_B;
  endproperty
  a_insert_priority: assert property (p_insert_priority) else $error("group B lost priority");

  property p_gate_mask;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (on_gate1 && !(s_q.aw_have && s_q.w_have)) |=> (sensor_gate_pulse_out & $past(s_q.gate_output_mask)) == 24'h000000;
  endproperty
  a_gate_mask: assert property (p_gate_mask) else $error("masked gate pulse passed");

  property p_line_count;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (line_end && !on_last_line && !(s_q.aw_have && s_q.w_have)) |=> s_q.line == $past(s_q.line) + 13'h0001;
  endproperty
  a_line_count: assert property (p_line_count) else $error("line count did not advance");

endmodule : ccd_vertical_field_sequencer

/* File: shared/ccd_vfs_map.svh */
// Register offsets, field positions, reset values and counts of the vertical field sequencer
`ifndef CCD_VFS_MAP_SVH
`define CCD_VFS_MAP_SVH
// Register byte offsets
`define VFS_CTRL_OFS 12'h000
`define VFS_LINE_TOTAL_OFS 12'h004
`define VFS_PIX_TOTAL_OFS 12'h008
`define VFS_LAST_PIX_OFS 12'h00C
`define VFS_PAIR_SEL_OFS 12'h010
`define VFS_MASK1_OFS 12'h014
`define VFS_MASK2_OFS 12'h018
`define VFS_SG_LINE1_OFS 12'h01C
`define VFS_SG_LINE2_OFS 12'h020
`define VFS_INSERT_OFS 12'h024
`define VFS_REP_A_OFS 12'h028
`define VFS_REP_B_OFS 12'h02C
`define VFS_STATUS_OFS 12'h030
`define VFS_REGION_OFS 12'h040
`define VFS_REGION_END 12'h064
`define VFS_PLEN_OFS 12'h080
`define VFS_PLEN_END 12'h090
`define VFS_TOG_OFS 12'h090
`define VFS_TOG_END 12'h0D0
`define VFS_SEQ_OFS 12'h100
`define VFS_SEQ_END 12'h180
// Field positions
`define VFS_CTRL_RUN_BIT 0
`define VFS_CTRL_CNT_LSB 16
`define VFS_REG_CHOICE_LSB 16
`define VFS_REG_MODE_LSB 24
`define VFS_SEQ_ADV_BIT 20
`define VFS_SEQ_RET_BIT 21
`define VFS_ST_REGION_LSB 16
`define VFS_ST_SEQ_LSB 24
// Reset values
`define VFS_LINE_TOTAL_RST 13'h0020
`define VFS_PIX_TOTAL_RST 13'h0040
`define VFS_LAST_PIX_RST 13'h0040
`define VFS_SG_LINE_RST 13'h1FFF
`define VFS_REGION_CNT_RST 4'h1
// Counts
`define VFS_REGIONS 9
`define VFS_SEQS 32
`define VFS_OUTS 24
`endif

/* File: shared/ccd_vfs_pkg.sv */
// Types shared by the vertical field sequencer
package ccd_vfs_pkg;
  // Per-region settings: start line, sequence choice, sweep and multiplier mode
  typedef struct packed {
    logic [1:0] wide_pulse_mode;
    logic [4:0] pattern_choice;
    logic [12:0] start_line;
  } region_t;

  // Pattern groups within a sequence
  typedef enum logic [1:0] {
    GRP_A,
    GRP_B,
    GRP_C,
    GRP_D
  } group_t;

  // Mode codes of a region
  typedef enum logic [1:0] {
    MODE_PLAIN,
    MODE_SWEEP,
    MODE_MULT,
    MODE_REGION_WIDE_PULSE_MODE
  } wide_pulse_t;
endpackage : ccd_vfs_pkg

/* File: tb/ccd_sensor_model.sv */
// Sensor side model: times each line from the line sync pulses
module ccd_sensor_model (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // Clock lines from the sequencer
  input wire logic [23:0] vertical_in,
  input wire logic [23:0] gate_in,
  input wire logic line_sync_in,
  // Length of the last completed line in cycles
  output logic [15:0] gap_out,
  // Pulses seen on the last phase clock during the last completed line
  output logic [7:0] pulses_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] cnt_q;
  logic last_q;
  logic [7:0] rise_cnt_q;
  logic rise;
  // A transfer or a sensor gate pulse on the last phase counts once, at its rising edge
  assign rise = (vertical_in[23] | gate_in[23]) & ~last_q;
  // The sensor has no view of the counters, only of the sync spacing and the pulses
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q <= 16'h0001;
      gap_out <= 16'h0000;
      last_q <= 1'b0;
      rise_cnt_q <= 8'h00;
      pulses_out <= 8'h00;
    end else begin
      last_q <= vertical_in[23] | gate_in[23];
      if (line_sync_in) begin
        gap_out <= cnt_q;
        cnt_q <= 16'h0001;
        pulses_out <= rise_cnt_q + 8'(rise);
        rise_cnt_q <= 8'h00;
      end else begin
        cnt_q <= cnt_q + 16'h0001;
        rise_cnt_q <= rise_cnt_q + 8'(rise);
      end
    end
  end
endmodule : ccd_sensor_model

/* File: tb/ccd_vertical_field_sequencer_tb.sv */
// Self-checking bench for the vertical field sequencer
module ccd_vertical_field_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, sync;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [23:0] vert, gate;
  logic [15:0] gap;
  logic [33:0] exp_q[$];
  int error_cnt = 0;
  int n_tests = 0;
  logic [11:0] rst_a [6] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h01C, 12'h020};
  logic [31:0] rst_v [6] = '{32'h0001_0000, 32'h20, 32'h40, 32'h40, 32'h1FFF, 32'h1FFF};
  logic [11:0] rw_a [5] = '{12'h010, 12'h014, 12'h018, 12'h01C, 12'h020};
  logic [31:0] rw_m [5] = '{32'hFF_FFFF, 32'hFF_FFFF, 32'hFF_FFFF, 32'h1FFF, 32'h1FFF};
  // Eight-line field, two regions, sequences 2-3-4 looping, then sequence 6
  logic [11:0] cfg_a [9] = '{12'h004, 12'h008, 12'h00C, 12'h040, 12'h044, 12'h108, 12'h10C, 12'h110, 12'h000};
  logic [31:0] cfg_v [9] = '{32'h8, 32'h10, 32'hC, 32'h2_0000, 32'h6_0006, 32'h10_0000, 32'h10_0000, 32'h20_0000,
    32'h2_0001};
  logic [7:0] pulses;
  // Expected level per cycle of a line: A at 2..3, inserted B at 5..8
  logic [9:0] wave = 10'h1EC;
  // Pattern set: pair choice, mask, gate line 3, lengths, toggles, B inserted at repetition 1, restart
  logic [11:0] pat_a [12] = '{12'h010, 12'h014, 12'h01C, 12'h080, 12'h084, 12'h090, 12'h094, 12'h0A4, 12'h024,
    12'h028, 12'h02C, 12'h000};
  logic [31:0] pat_v [12] = '{32'hFF, 32'h0, 32'h3, 32'h4, 32'h4, 32'h1, 32'h3, 32'h4, 32'h7, 32'h2, 32'h1,
    32'h2_0001};

  ccd_vertical_field_sequencer u_dut (
    .sys_clk_in(sys_clk), .rst_n_in(rst_n),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .vertical_out(vert), .sensor_gate_pulse_out(gate), .line_sync_out(sync));
  ccd_sensor_model u_sensor (.sys_clk_in(sys_clk), .rst_n_in(rst_n), .vertical_in(vert), .gate_in(gate),
    .line_sync_in(sync), .gap_out(gap), .pulses_out(pulses));

  // Clock at 50 MHz
  initial begin
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [33:0] e, input logic [33:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk

  // Write with both channels offered together; bready held until the answer
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk({32'h0, er}, {32'h0, bresp});
  endtask : wr

  // Read: the expected response and data go to the queue first
  task automatic rd(input logic [11:0] a, input logic [33:0] e);
    exp_q.push_back(e);
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask : rd

  // Each read answer is matched against the oldest note
  always @(posedge sys_clk) begin
    if (rvalid === 1'b1 && rready && exp_q.size() > 0) chk(exp_q.pop_front(), {rresp, rdata});
  end

  // Expected status word for a line of the test field
  function automatic logic [33:0] st(input int l);
    logic [4:0] s;
    s = (l < 6) ? 5'(2 + l % 3) : 5'h6;
    return {2'h0, 3'h0, s, 4'h0, (l < 6) ? 4'h0 : 4'h1, 3'h0, 13'(l)};
  endfunction : st

  task final_report;
    $display("compares %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : final_report

  // Main sequence
  initial begin
    logic [31:0] r;
    void'($urandom(32'hDC19));
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 6; i++) rd(rst_a[i], {2'h0, rst_v[i]});
    rd(12'h034, {2'h2, 32'h0});
    wr(12'h034, 32'h1, 2'h2);
    $display("test reset_and_map done");
    for (int i = 0; i < 5; i++) begin
      r = $urandom;
      wr(rw_a[i], r, 2'h0);
      rd(rw_a[i], {2'h0, r & rw_m[i]});
    end
    $display("test field_registers done");
    wr(12'h020, 32'h1FFF, 2'h0);
    for (int i = 0; i < 9; i++) wr(cfg_a[i], cfg_v[i], 2'h0);
    rd(12'h030, st(0));
    for (int i = 1; i < 10; i++) begin
      @(posedge sys_clk iff sync === 1'b1);
      #1;
      if (i >= 2) chk({18'h0, 16'(((i - 1) % 8 == 7) ? 12 : 16)}, {18'h0, gap});
      rd(12'h030, st(i % 8));
    end
    $display("test sequence_loop done");
    r = $urandom;
    pat_v[1] = r;
    for (int i = 0; i < 12; i++) wr(pat_a[i], pat_v[i], 2'h0);
    // Lines counted from the restart; line 3 is the gate line
    for (int ln = 1; ln < 9; ln++) begin
      @(posedge sys_clk iff sync === 1'b1);
      for (int k = 1; k < 10; k++) begin
        #1;
        if (k == 1 && ln >= 2) chk({26'h0, ((ln - 1) % 8 == 3 && r[23]) ? 8'h00 : 8'h02}, {26'h0, pulses});
        chk({10'h0, (ln % 8 != 3 && wave[k]) ? 24'hFFFF00 : 24'h0}, {10'h0, vert});
        chk({10'h0, (ln % 8 == 3 && wave[k]) ? 24'hFFFF00 & ~r[23:0] : 24'h0}, {10'h0, gate});
        @(posedge sys_clk);
      end
    end
    $display("test pattern_and_gate done");
    final_report();
  end

  // Watchdog for a hung handshake
  initial begin
    #400000;
    error_cnt++;
    final_report();
  end
endmodule : ccd_vertical_field_sequencer_tb
